// ==== hw/owsc_pkg.sv ====
/*
 * Constants for the option word startup configuration loader: ROM locations,
 * bus offsets, option field positions, reset values and timing counts.
 * Assumes a 100 MHz system clock.
 */
package owsc_pkg;
	localparam int unsigned CLK_MHZ = 100;

	// Option words in program ROM, also their byte addresses on the register bus; then the status and clock select registers
	localparam logic [31:0] ENDIAN_WORD_ADDR = 32'hffff_ff80;
	localparam logic [31:0] STARTUP_WORD_ADDR = 32'hffff_ff88;
	localparam logic [31:0] LOAD_STATUS_ADDR = 32'hffff_ff90;
	localparam logic [31:0] CLOCK_SELECT_ADDR = 32'hffff_ff94;

	// Value of an erased ROM block
	localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

	// Startup option word fields
	localparam int unsigned FAST_POWER_ON_BIT = 0;
	localparam int unsigned LOWVOLT_EN_N_BIT = 1;
	localparam int unsigned LOWVOLT_LVL_LSB = 4;
	localparam int unsigned LOWVOLT_LVL_W = 4;
	localparam int unsigned FAST_OSC_EN_N_BIT = 8;
	localparam logic [3:0] LOWVOLT_LVL_MIN = 4'h4;
	localparam logic [3:0] LOWVOLT_LVL_MAX = 4'hd;

	// Endian option word field
	localparam int unsigned ENDIAN_W = 3;
	localparam logic [2:0] ENDIAN_BIG = 3'h0;
	localparam logic [2:0] ENDIAN_LITTLE = 3'h7;

	// Load status register bits
	localparam int unsigned STAT_DONE_BIT = 0;
	localparam int unsigned STAT_BOOT_BIT = 1;
	localparam int unsigned STAT_APPLIED_BIT = 2;
	localparam int unsigned STAT_OSC_BIT = 3;
	localparam int unsigned STAT_LITTLE_BIT = 4;

	// Clock source select field
	localparam int unsigned CLK_SEL_W = 3;
	localparam logic [2:0] CLK_SEL_RESET = 3'h0;

	// Oscillator settle time, rounded up to whole cycles
	localparam int unsigned FAST_OSC_SETTLE_NS = 1000;
	localparam int unsigned FAST_OSC_SETTLE_CYC = (FAST_OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
	// Cycles given to the boot mode synchroniser before the fetch starts
	localparam int unsigned SYNC_WARM_CYC = 4;
	localparam int unsigned CNT_W = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		LD_WARM = 3'b000,
		LD_FETCH_ENDIAN = 3'b001,
		LD_FETCH_STARTUP = 3'b010,
		LD_SETTLE = 3'b011,
		LD_RUN = 3'b100
	} owsc_load_t;

	typedef enum logic [2:0] {
		SEL_ENDIAN = 3'b000,
		SEL_STARTUP = 3'b001,
		SEL_STATUS = 3'b010,
		SEL_CLKSEL = 3'b011,
		SEL_NONE = 3'b111
	} owsc_sel_t;
endpackage : owsc_pkg

// ==== hw/owsc_loader.sv ====
/*
 * Option word startup configuration loader: fetches the endian and startup
 * option words from program ROM after reset, turns them into fixed settings,
 * holds the CPU in reset until the settings and the oscillator are ready, and
 * shows the words over an AXI4-Lite slave.
 * Assumes a ROM port on the same clock that answers a held request with a
 * one-cycle ack, and a boot mode pin from outside the clock domain.
 */
// What this block does
// - Fetch both words; endian word lower address
// - Erased startup word reads ones, not applied
// - Boot mode ignores the startup word
// - Bit 0 selects fast or normal startup
// - Bit 1 low enables startup voltage reset
// - Enable bit low forces monitor reset on
// - Bits 7..4 pick one of ten levels
// - Oscillator runs after reset when bit low
// - Only a CPU write switches clock source
// - Wait oscillator settle before releasing CPU
// - Reserved bits read back as programmed
// - Erased endian word selects little endian
// - Option words cannot be written by code
`timescale 1ns/10ps
module owsc_loader (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic boot_mode_pin,
	output logic rom_req,
	output logic [31:0] rom_addr,
	input wire logic rom_ack,
	input wire logic [31:0] rom_rdata,
	input wire logic rom_blank,
	output logic cpu_reset_hold,
	output logic fast_power_on_select,
	output logic startup_lowvolt_reset_enable_n,
	output logic [owsc_pkg::LOWVOLT_LVL_W-1:0] startup_lowvolt_level,
	output logic monitor1_reset_active,
	output logic fast_internal_oscillator_run,
	output logic cpu_little_endian,
	output logic [owsc_pkg::CLK_SEL_W-1:0] clock_source_select,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import owsc_pkg::*;

	function automatic owsc_sel_t addr_sel(input logic [31:0] addr);
		if (addr == ENDIAN_WORD_ADDR) begin
			addr_sel = SEL_ENDIAN;
		end else if (addr == STARTUP_WORD_ADDR) begin
			addr_sel = SEL_STARTUP;
		end else if (addr == LOAD_STATUS_ADDR) begin
			addr_sel = SEL_STATUS;
		end else if (addr == CLOCK_SELECT_ADDR) begin
			addr_sel = SEL_CLKSEL;
		end else begin
			addr_sel = SEL_NONE;
		end
	endfunction : addr_sel

	// Boot mode pin synchroniser; a change counts once stages two and three agree
	logic [2:0] boot_sync_r;
	logic boot_mode_r, boot_mode_nxt;

	always_comb begin
		boot_mode_nxt = boot_mode_r;
		if (boot_sync_r[1] == boot_sync_r[2]) begin
			boot_mode_nxt = boot_sync_r[2];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			boot_sync_r <= 3'h0;
			boot_mode_r <= 1'b0;
		end else begin
			boot_sync_r <= {boot_sync_r[1:0], boot_mode_pin};
			boot_mode_r <= boot_mode_nxt;
		end
	end

	// Load sequencer
	owsc_load_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [31:0] endian_word_r, endian_word_nxt;
	logic [31:0] startup_word_r, startup_word_nxt;
	logic applied_r, applied_nxt;
	logic [31:0] eff_startup;

	// Settings in force: a word that is not applied acts as an erased one
	assign eff_startup = applied_r ? startup_word_r : ERASED_WORD;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		endian_word_nxt = endian_word_r;
		startup_word_nxt = startup_word_r;
		applied_nxt = applied_r;
		case (state_r)
			LD_WARM: begin
				cnt_nxt = cnt_r + 16'h1;
				if (cnt_r == CNT_W'(SYNC_WARM_CYC - 1)) begin
					cnt_nxt = 16'h0;
					state_nxt = LD_FETCH_ENDIAN;
				end
			end
			LD_FETCH_ENDIAN: begin
				if (rom_ack) begin
					endian_word_nxt = rom_blank ? ERASED_WORD : rom_rdata;
					state_nxt = LD_FETCH_STARTUP;
				end
			end
			LD_FETCH_STARTUP: begin
				if (rom_ack) begin
					startup_word_nxt = rom_blank ? ERASED_WORD : rom_rdata;
					applied_nxt = !rom_blank && !boot_mode_r;
					state_nxt = LD_SETTLE;
				end
			end
			LD_SETTLE: begin
				// Oscillator started by the option bit must settle first
				if (applied_r && !startup_word_r[FAST_OSC_EN_N_BIT]) begin
					cnt_nxt = cnt_r + 16'h1;
					if (cnt_r == CNT_W'(FAST_OSC_SETTLE_CYC - 1)) begin
						state_nxt = LD_RUN;
					end
				end else begin
					state_nxt = LD_RUN;
				end
			end
			LD_RUN: begin
				// Words are never sampled again until the next reset
				state_nxt = LD_RUN;
			end
			default: begin
				state_nxt = LD_WARM;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= LD_WARM;
			cnt_r <= 16'h0;
			endian_word_r <= ERASED_WORD;
			startup_word_r <= ERASED_WORD;
			applied_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			endian_word_r <= endian_word_nxt;
			startup_word_r <= startup_word_nxt;
			applied_r <= applied_nxt;
		end
	end

	assign rom_req = (state_r == LD_FETCH_ENDIAN) || (state_r == LD_FETCH_STARTUP);
	assign rom_addr = (state_r == LD_FETCH_STARTUP) ? STARTUP_WORD_ADDR : ENDIAN_WORD_ADDR;
	assign cpu_reset_hold = (state_r != LD_RUN);

	assign fast_power_on_select = eff_startup[FAST_POWER_ON_BIT];
	assign startup_lowvolt_reset_enable_n = eff_startup[LOWVOLT_EN_N_BIT];
	assign startup_lowvolt_level = eff_startup[LOWVOLT_LVL_LSB +: LOWVOLT_LVL_W];
	// Independent of the fast startup bit
	assign monitor1_reset_active = !eff_startup[LOWVOLT_EN_N_BIT];
	assign fast_internal_oscillator_run = !eff_startup[FAST_OSC_EN_N_BIT];
	// Prohibited codes fall to little endian, the erased default
	assign cpu_little_endian = (endian_word_r[ENDIAN_W-1:0] != ENDIAN_BIG);

	// Register bus: writes
	logic aw_got_r, aw_got_nxt;
	logic w_got_r, w_got_nxt;
	logic [31:0] awaddr_r, awaddr_nxt;
	logic [2:0] wdata_r, wdata_nxt;
	logic wstrb0_r, wstrb0_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic [CLK_SEL_W-1:0] clk_sel_r, clk_sel_nxt;
	owsc_sel_t wsel;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign wsel = addr_sel(awaddr_r);

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		clk_sel_nxt = clk_sel_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[CLK_SEL_W-1:0];
			wstrb0_nxt = s_axi_wstrb[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			if (wsel == SEL_CLKSEL) begin
				bresp_nxt = RESP_OKAY;
				// The clock source moves only on this write
				if (wstrb0_r) begin
					clk_sel_nxt = wdata_r;
				end
			end else if (wsel == SEL_NONE) begin
				bresp_nxt = RESP_DECERR;
			end else begin
				// Option words and status refuse writes and keep their value
				bresp_nxt = RESP_SLVERR;
			end
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 32'h0;
			wdata_r <= 3'h0;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			clk_sel_r <= CLK_SEL_RESET;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			clk_sel_r <= clk_sel_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign clock_source_select = clk_sel_r;

	// Register bus: reads
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic [31:0] status_word;
	owsc_sel_t rsel;

	assign s_axi_arready = !rvalid_r;
	assign rsel = addr_sel(s_axi_araddr);

	always_comb begin
		status_word = 32'h0;
		status_word[STAT_DONE_BIT] = (state_r == LD_RUN);
		status_word[STAT_BOOT_BIT] = boot_mode_r;
		status_word[STAT_APPLIED_BIT] = applied_r;
		status_word[STAT_OSC_BIT] = fast_internal_oscillator_run;
		status_word[STAT_LITTLE_BIT] = cpu_little_endian;
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			if (rsel == SEL_ENDIAN) begin
				rdata_nxt = endian_word_r;
			end else if (rsel == SEL_STARTUP) begin
				rdata_nxt = startup_word_r;
			end else if (rsel == SEL_STATUS) begin
				rdata_nxt = status_word;
			end else if (rsel == SEL_CLKSEL) begin
				rdata_nxt = {29'h0, clk_sel_r};
			end else begin
				rdata_nxt = 32'h0;
				rresp_nxt = RESP_DECERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule : owsc_loader

// ==== dv/owsc_rom_model.sv ====
/* ROM model that serves the two option words to the loader.
 * Assumes the loader holds rom_req and rom_addr until it sees rom_ack. */
`timescale 1ns/10ps
module owsc_rom_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic rom_req,
	input wire logic [31:0] rom_addr,
	input wire logic [31:0] endian_word,
	input wire logic [31:0] startup_word,
	input wire logic endian_blank,
	input wire logic startup_blank,
	input wire logic [3:0] ack_delay,
	output logic rom_ack,
	output logic [31:0] rom_rdata,
	output logic rom_blank
);
	import owsc_pkg::*;
	logic [3:0] wait_r;
	logic lo;
	logic go;
	assign lo = rom_addr == ENDIAN_WORD_ADDR;
	assign go = !sys_rst && rom_req && rom_ack === 1'b0 && wait_r == ack_delay;
	always_ff @(posedge clock) begin
		if (sys_rst || !rom_req || rom_ack) begin
			wait_r <= 4'h0;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
		rom_ack <= go;
		// Erased blocks still put their stale cells on the data lines
		if (go) begin
			rom_rdata <= lo ? endian_word : startup_word;
			rom_blank <= lo ? endian_blank : startup_blank;
		end else begin
			// Lines toggle between acks so stale data is never mistaken for a word
			rom_rdata <= sys_rst ? 32'h5a5a_a5a5 : ~rom_rdata;
			rom_blank <= !sys_rst && !rom_blank;
		end
	end
endmodule : owsc_rom_model

// ==== dv/owsc_loader_sva.sv ====
/* Port checker for the option word loader.
 * Assumes the loader ports named as in owsc_loader; bound below. */
`timescale 1ns/10ps
module owsc_loader_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic rom_req,
	input wire logic [31:0] rom_addr,
	input wire logic rom_ack,
	input wire logic cpu_reset_hold,
	input wire logic fast_power_on_select,
	input wire logic startup_lowvolt_reset_enable_n,
	input wire logic [owsc_pkg::LOWVOLT_LVL_W-1:0] startup_lowvolt_level,
	input wire logic monitor1_reset_active,
	input wire logic fast_internal_oscillator_run,
	input wire logic cpu_little_endian,
	input wire logic [owsc_pkg::CLK_SEL_W-1:0] clock_source_select,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid
);
	import owsc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic [8:0] cfg;
	logic w_hs;
	assign cfg = {fast_power_on_select, startup_lowvolt_reset_enable_n, startup_lowvolt_level,
		monitor1_reset_active, fast_internal_oscillator_run, cpu_little_endian};
	assign w_hs = s_axi_wvalid && s_axi_wready;
	property p_order;
		rom_req && rom_ack && rom_addr == ENDIAN_WORD_ADDR |=> rom_req && rom_addr == STARTUP_WORD_ADDR;
	endproperty
	a_order: assert property (p_order) else $error("startup fetch missing");
	property p_req;
		rom_req && !rom_ack |=> rom_req && $stable(rom_addr);
	endproperty
	a_req: assert property (p_req) else $error("fetch request dropped");
	property p_mon;
		monitor1_reset_active != startup_lowvolt_reset_enable_n;
	endproperty
	a_mon: assert property (p_mon) else $error("monitor reset mismatch");
	property p_hold;
		!cpu_reset_hold && !$past(cpu_reset_hold) |-> $stable(cfg);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved while running");
	// Slow release only when the oscillator was started by the option bit
	property p_settle;
		$fell(rom_req) && fast_internal_oscillator_run |-> ##90 cpu_reset_hold ##[1:20] !cpu_reset_hold;
	endproperty
	a_settle: assert property (p_settle) else $error("settle wait wrong");
	property p_quick;
		$fell(rom_req) && !fast_internal_oscillator_run |-> ##[0:3] !cpu_reset_hold;
	endproperty
	a_quick: assert property (p_quick) else $error("release late");
	property p_clksel;
		!$stable(clock_source_select) |-> $past(w_hs) || $past(w_hs, 2);
	endproperty
	a_clksel: assert property (p_clksel) else $error("clock select moved alone");
	property p_bresp;
		s_axi_awvalid && s_axi_awready && w_hs |-> ##2 s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response late");
	c_slow: cover property ($fell(rom_req) && fast_internal_oscillator_run);
	c_run: cover property ($fell(cpu_reset_hold));
	c_wr: cover property (s_axi_bvalid);
endmodule : owsc_loader_chk
bind owsc_loader owsc_loader_chk u_chk (.*);

// ==== dv/testbench.sv ====
/* Self-checking bench for owsc_loader with a ROM model.
 * Assumes the loader and its checker are compiled first. */
`timescale 1ns/10ps
module testbench;
	import owsc_pkg::*;
	typedef struct packed {
		logic [31:0] ew;
		logic [31:0] sw;
		logic eb;
		logic sb;
		logic bt;
		logic [3:0] dly;
	} owsc_row_t;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic boot_mode_pin = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [31:0] ew_m = 32'h0, sw_m = 32'h0;
	logic eb_m = 1'b0, sb_m = 1'b0;
	logic [3:0] dly_m = 4'h0;
	logic rom_req, rom_ack, rom_blank, cpu_reset_hold, fast_power_on_select;
	logic startup_lowvolt_reset_enable_n, monitor1_reset_active, fast_internal_oscillator_run;
	logic cpu_little_endian, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] rom_addr, rom_rdata, s_axi_rdata;
	logic [3:0] startup_lowvolt_level;
	logic [2:0] clock_source_select;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0;
	int checks_done = 0;
	// Programmed images keep reserved bits at one and use legal codes only
	owsc_row_t rows [4] = '{
		'{32'hffff_fff8, 32'hffff_fe4e, 1'b0, 1'b0, 1'b0, 4'h0},
		'{32'hffff_ffff, 32'hffff_ffdc, 1'b0, 1'b0, 1'b0, 4'h3},
		'{32'h0, 32'h0, 1'b1, 1'b1, 1'b0, 4'h1},
		'{32'hffff_fff8, 32'hffff_fe4e, 1'b0, 1'b0, 1'b1, 4'h2}};
	always #5 clock = ~clock;
	owsc_loader uut (.*);
	owsc_rom_model u_rom (.clock(clock), .sys_rst(sys_rst), .rom_req(rom_req),
		.rom_addr(rom_addr), .endian_word(ew_m), .startup_word(sw_m), .endian_blank(eb_m),
		.startup_blank(sb_m), .ack_delay(dly_m), .rom_ack(rom_ack), .rom_rdata(rom_rdata),
		.rom_blank(rom_blank));
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic tmo;
		failures++;
		print_verdict();
	endtask : tmo
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
		bit aw = 1'b1, w = 1'b1, b = 1'b1;
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && b; n++) begin
			@(posedge clock);
			if (s_axi_bvalid === 1'b1 && !aw && !w) begin
				b = 1'b0;
				s_axi_bready <= 1'b0;
				chk("bresp", s_axi_bresp, er);
			end
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (b)
			tmo();
		@(posedge clock);
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, ed, input logic [1:0] er);
		bit ar = 1'b1, r = 1'b1;
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && r; n++) begin
			@(posedge clock);
			if (s_axi_rvalid === 1'b1 && !ar) begin
				r = 1'b0;
				s_axi_rready <= 1'b0;
				chk("rdata", s_axi_rdata, ed);
				chk("rresp", s_axi_rresp, er);
			end
			if (ar && s_axi_arready === 1'b1) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (r)
			tmo();
		@(posedge clock);
	endtask : axi_rd
	task automatic run_case(input owsc_row_t r);
		logic [31:0] eff;
		logic [31:0] st;
		int n;
		eff = (r.sb || r.bt) ? ERASED_WORD : r.sw;
		// Status word expected from the row itself, not from the loader
		st = 32'h0;
		st[STAT_DONE_BIT] = 1'b1;
		st[STAT_BOOT_BIT] = r.bt;
		st[STAT_APPLIED_BIT] = !(r.sb || r.bt);
		st[STAT_OSC_BIT] = !eff[8];
		st[STAT_LITTLE_BIT] = r.eb || r.ew[2:0] != 3'h0;
		ew_m <= r.ew;
		sw_m <= r.sw;
		eb_m <= r.eb;
		sb_m <= r.sb;
		dly_m <= r.dly;
		boot_mode_pin <= r.bt;
		sys_rst <= 1'b1;
		repeat (10) @(posedge clock);
		chk("hold", cpu_reset_hold, 32'h1);
		sys_rst <= 1'b0;
		for (n = 0; n < 300 && cpu_reset_hold !== 1'b0; n++)
			@(posedge clock);
		if (n == 300)
			tmo();
		chk("fast", fast_power_on_select, eff[0]);
		chk("lv_en_n", startup_lowvolt_reset_enable_n, eff[1]);
		chk("level", startup_lowvolt_level, eff[7:4]);
		// Monitor reset at release follows bit 1, so early software setup finds it armed when that bit is low
		chk("mon", monitor1_reset_active, !eff[1]);
		chk("osc", fast_internal_oscillator_run, !eff[8]);
		chk("little", cpu_little_endian, r.eb || r.ew[2:0] != 3'h0);
		chk("clksel", clock_source_select, 32'h0);
		axi_rd(ENDIAN_WORD_ADDR, r.eb ? ERASED_WORD : r.ew, RESP_OKAY);
		axi_rd(STARTUP_WORD_ADDR, r.sb ? ERASED_WORD : r.sw, RESP_OKAY);
		axi_rd(LOAD_STATUS_ADDR, st, RESP_OKAY);
	endtask : run_case
	initial begin
		for (int i = 0; i < 4; i++) begin
			run_case(rows[i]);
		end
		for (int l = 4; l <= 13; l++) begin
			run_case(owsc_row_t'{32'hffff_ffff, {24'hff_ffff, 4'(l), 4'hc}, 1'b0, 1'b0, 1'b0, 4'(l)});
		end
		run_case(rows[0]);
		axi_wr(CLOCK_SELECT_ADDR, 32'h5, 4'h1, RESP_OKAY);
		chk("clksel", clock_source_select, 32'h5);
		axi_wr(CLOCK_SELECT_ADDR, 32'h2, 4'he, RESP_OKAY);
		axi_rd(CLOCK_SELECT_ADDR, 32'h5, RESP_OKAY);
		chk("osc", fast_internal_oscillator_run, 32'h1);
		axi_wr(STARTUP_WORD_ADDR, 32'h0, 4'hf, RESP_SLVERR);
		axi_wr(ENDIAN_WORD_ADDR, 32'h0, 4'hf, RESP_SLVERR);
		// A new ROM image must not reach the settings before the next reset
		sw_m <= 32'h0;
		ew_m <= 32'h0;
		axi_rd(STARTUP_WORD_ADDR, rows[0].sw, RESP_OKAY);
		chk("fast", fast_power_on_select, 32'h0);
		chk("little", cpu_little_endian, 32'h0);
		axi_rd(32'h0000_0010, 32'h0, RESP_DECERR);
		axi_wr(32'h0000_0010, 32'h1, 4'hf, RESP_DECERR);
		print_verdict();
	end
endmodule : testbench
